// >>> hdl/bxa_pkg.sv
// Shared constants and types of the base-x / sgmii negotiation block.
// Assumes one core clock at CLK_MHZ and a synchronous active-low reset.
package bxa_pkg;

  typedef logic [15:0] bxa_word_t;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam real CLK_MHZ            = 40.0;
  localparam real LINK_TIME_BASEX_MS = 10.0;
  localparam real LINK_TIME_SGMII_MS = 1.6;
  localparam int  LINK_CYC_BASEX     = int'($ceil(LINK_TIME_BASEX_MS * 1000.0 * CLK_MHZ));
  localparam int  LINK_CYC_SGMII     = int'($ceil(LINK_TIME_SGMII_MS * 1000.0 * CLK_MHZ));
  localparam int  TIMER_W            = 19;
  localparam int  MATCH_COUNT        = 3;

  // ---------------------------------------------------------------
  // Ability word layout
  // ---------------------------------------------------------------
  localparam int        BIT_ACK      = 14;
  localparam int        BIT_LINK     = 15;
  localparam int        RFLT_LO      = 12;
  localparam int        PAUSE_LO     = 7;
  localparam int        SPEED_LO     = 10;
  localparam int        BIT_DUPLEX   = 12;
  localparam int        BUF_ERR_BIT  = 2;
  localparam bxa_word_t CFG_ZERO     = 16'h0000;
  localparam bxa_word_t ACK_MASK     = 16'h4000;
  localparam bxa_word_t SGMII_WORD   = 16'h0001;
  localparam bxa_word_t ADV_RESET    = 16'h0020;
  localparam logic [1:0] SPEED_1000  = 2'h2;

  // ---------------------------------------------------------------
  // Negotiation states, Gray coded along the usual path
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_AN_ENABLE    = 3'h0,
    S_AN_RESTART   = 3'h1,
    S_ABILITY      = 3'h3,
    S_ACK_DETECT   = 3'h2,
    S_COMPLETE_ACK = 3'h6,
    S_IDLE_DETECT  = 3'h7,
    S_LINK_OK      = 3'h5,
    S_DISABLE      = 3'h4
  } bxa_state_t;

endpackage

// >>> hdl/bxa_link_if.sv
// Carrier between the negotiation controller, its link timer and matcher.
// Assumes all three parties run on the same core clock.
interface bxa_link_if;
  import bxa_pkg::*;
  logic      timer_start;
  logic      timer_sgmii;
  logic      timer_done;
  logic      rx_valid;
  bxa_word_t rx_word;
  logic      rx_idle;
  logic      frag;
  logic      buf_err;
  logic      ability_match;
  logic      ack_match;
  logic      idle_match;
  bxa_word_t match_word;
  modport ctl (output timer_start, timer_sgmii, rx_valid, rx_word, rx_idle, frag, buf_err,
               input  timer_done, ability_match, ack_match, idle_match, match_word);
  modport tmr (input timer_start, timer_sgmii, output timer_done);
  modport mat (input  rx_valid, rx_word, rx_idle, frag, buf_err,
               output ability_match, ack_match, idle_match, match_word);
endinterface

// >>> hdl/bxa_link_timer.sv
// Link timer: one-shot, restarted by the controller, length by standard.
// Assumes start is a one-cycle request from the controller.
module bxa_link_timer #(
  parameter int BASEX_CYCLES = bxa_pkg::LINK_CYC_BASEX,
  parameter int SGMII_CYCLES = bxa_pkg::LINK_CYC_SGMII
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  bxa_link_if.tmr   lnk
);
  import bxa_pkg::*;

  localparam logic [TIMER_W-1:0] LIM_BASEX = TIMER_W'(BASEX_CYCLES - 1);
  localparam logic [TIMER_W-1:0] LIM_SGMII = TIMER_W'(SGMII_CYCLES - 1);

  typedef struct packed {
    logic [TIMER_W-1:0] cnt;
    logic [TIMER_W-1:0] lim;
    logic               done;
  } bxa_tmr_st_t;

  bxa_tmr_st_t st_r;
  bxa_tmr_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (lnk.timer_start) begin
      st_nxt.cnt  = '0;
      st_nxt.done = 1'b0;
      st_nxt.lim  = lnk.timer_sgmii ? LIM_SGMII : LIM_BASEX;
    end else if (!st_r.done) begin
      if (st_r.cnt == st_r.lim) begin
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign lnk.timer_done = st_r.done;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_timer_length: assert property ($rose(st_r.done) |-> st_r.cnt == st_r.lim)
    else $error("link timer expired at wrong count");
  a_timer_mode: assert property (i_ce && lnk.timer_start |=>
      st_r.lim == ($past(lnk.timer_sgmii) ? LIM_SGMII : LIM_BASEX))
    else $error("link timer length does not follow standard");
endmodule

// >>> hdl/bxa_rx_matcher.sv
// Receive matcher: counts repeated ability words, acknowledges and idles.
// Assumes config and idle indications are never high in the same cycle.
module bxa_rx_matcher (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  bxa_link_if.mat   lnk
);
  import bxa_pkg::*;

  localparam logic [1:0] FULL = 2'(MATCH_COUNT);

  typedef struct packed {
    bxa_word_t  last;
    logic [1:0] cnt;
    logic [1:0] ack_cnt;
    logic [1:0] idle_cnt;
  } bxa_mat_st_t;

  bxa_mat_st_t st_r;
  bxa_mat_st_t st_nxt;
  logic        same;

  always_comb begin
    st_nxt = st_r;
    same   = ({lnk.rx_word[15], lnk.rx_word[13:0]} == {st_r.last[15], st_r.last[13:0]});
    if (lnk.buf_err) begin
      // Slipped buffer: start counting afresh, negotiation itself goes on
      st_nxt.cnt      = 2'h0;
      st_nxt.ack_cnt  = 2'h0;
      st_nxt.idle_cnt = 2'h0;
    end else if (!lnk.frag) begin
      // Fragments from clock correction are skipped, never counted
      if (lnk.rx_valid) begin
        st_nxt.last     = lnk.rx_word;
        st_nxt.idle_cnt = 2'h0;
        st_nxt.cnt      = !same ? 2'h1 : (st_r.cnt == FULL) ? FULL : st_r.cnt + 2'h1;
        if (!lnk.rx_word[BIT_ACK]) begin
          st_nxt.ack_cnt = 2'h0;
        end else if (same && st_r.last[BIT_ACK]) begin
          st_nxt.ack_cnt = (st_r.ack_cnt == FULL) ? FULL : st_r.ack_cnt + 2'h1;
        end else begin
          st_nxt.ack_cnt = 2'h1;
        end
      end else if (lnk.rx_idle) begin
        st_nxt.cnt      = 2'h0;
        st_nxt.ack_cnt  = 2'h0;
        st_nxt.idle_cnt = (st_r.idle_cnt == FULL) ? FULL : st_r.idle_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign lnk.ability_match = (st_r.cnt == FULL);
  assign lnk.ack_match     = (st_r.cnt == FULL) && (st_r.ack_cnt == FULL);
  assign lnk.idle_match    = (st_r.idle_cnt == FULL);
  assign lnk.match_word    = st_r.last;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_clean_idle;
    i_ce && lnk.rx_idle && !lnk.rx_valid && !lnk.frag && !lnk.buf_err;
  endsequence

  // Idle sets arrive every other cycle, so allow one quiet cycle between them
  sequence s_idle_gap;
    !lnk.rx_valid && !lnk.buf_err;
  endsequence

  a_idle_count: assert property (s_clean_idle ##1 s_idle_gap ##1 s_clean_idle ##1
      s_idle_gap ##1 s_clean_idle |=> lnk.idle_match)
    else $error("three idles not recognised");
  a_frag_hold: assert property (i_ce && lnk.frag && !lnk.buf_err |=> $stable(st_r))
    else $error("fragment disturbed the match counters");
  a_buf_clear: assert property (i_ce && lnk.buf_err |=>
      !lnk.ability_match && !lnk.idle_match)
    else $error("buffer error did not clear matching");
endmodule

// >>> hdl/bxa_autoneg.sv
// Gigabit base-x / sgmii ability exchange controller with plain control ports.
// Assumes receive decode, sync detect and transmit encoding live outside.
//
// Notes on behaviour
// - Restart on reset, sync loss, partner restart or either restart input.
// - Send advertisement word, with fault, duplex and pause, while negotiating in base-x.
// - Advertisement also loads from vector, qualified by strobe with management.
// - Capture the partner's ability word while advertising.
// - Show partner remote fault and pause on status outputs.
// - Raise the negotiation-complete status bit when a cycle finishes.
// - Link timer lasts 10 ms in base-x and 1.6 ms in sgmii.
// - Sgmii words carry speed and duplex; mirror them on status outputs.
// - Sgmii phy mode forwards external phy abilities in the exchange.
// - Both link ends must agree on negotiation enabled or disabled.
// - 2.5G behaves as 1G; slow sgmii rates unsupported at 2.5G.
// - Interrupt enabled, disabled and cleared by control; disabled reads zero.
// - Interrupt rises on completion and holds until software writes zero; the code also clears it when the interrupt is disabled.
// - Idle pairs inserted or removed in the gap must not upset matching.
// - Use the correction count to skip ordered-set fragments.
// - Elastic buffer errors restart matching but negotiation still completes.
module bxa_autoneg #(
  parameter int BASEX_CYCLES = bxa_pkg::LINK_CYC_BASEX,
  parameter int SGMII_CYCLES = bxa_pkg::LINK_CYC_SGMII
) (
  input  wire  logic               i_clk,
  input  wire  logic               i_rst_n,
  input  wire  logic               i_ce,
  input  wire  logic               i_an_enable,
  input  wire  logic               i_restart_ctl,
  input  wire  logic               i_negotiation_restart_input,
  input  wire  logic               i_mgmt_present,
  input  wire  logic               i_adv_write,
  input  wire  bxa_pkg::bxa_word_t i_adv_wdata,
  input  wire  bxa_pkg::bxa_word_t i_advert_config_word,
  input  wire  logic               i_advert_config_strobe,
  input  wire  logic               i_sgmii_mode,
  input  wire  logic               i_sgmii_phy_mode,
  input  wire  bxa_pkg::bxa_word_t i_phy_abilities,
  input  wire  logic               i_rate_2g5,
  input  wire  logic               i_irq_enable,
  input  wire  logic               i_irq_status_write,
  input  wire  logic               i_irq_status_wdata,
  input  wire  logic               i_sync_ok,
  input  wire  logic               i_rx_config_valid,
  input  wire  bxa_pkg::bxa_word_t i_rx_config_word,
  input  wire  logic               i_rx_idle,
  input  wire  logic               i_second_correction_seq_enable,
  input  wire  logic [2:0]         i_clk_cor_cnt,
  input  wire  logic [2:0]         i_buf_status,
  output logic                     o_tx_config_en,
  output bxa_pkg::bxa_word_t       o_tx_config_word,
  output bxa_pkg::bxa_word_t       o_advert_word,
  output bxa_pkg::bxa_word_t       o_partner_ability,
  output logic                     o_an_complete,
  output logic                     o_negotiation_done_irq,
  output logic [1:0]               o_status_remote_fault,
  output logic [1:0]               o_status_pause,
  output logic [1:0]               o_status_speed,
  output logic                     o_status_duplex,
  output logic                     o_status_partner_link,
  output logic                     o_rate_unsupported
);
  import bxa_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    bxa_state_t state;
    logic       mode_sgmii;
    bxa_word_t  adv;
    bxa_word_t  partner;
    bxa_word_t  tx_word;
    logic       tx_en;
    logic       complete;
    logic       irq;
    logic       unsup;
  } bxa_ctl_st_t;

  bxa_ctl_st_t st_r;
  bxa_ctl_st_t st_nxt;
  logic        restart_any;
  logic        consistent;
  bxa_word_t   base_word;

  bxa_link_if lnk ();

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  bxa_link_timer #(
    .BASEX_CYCLES (BASEX_CYCLES),
    .SGMII_CYCLES (SGMII_CYCLES)
  ) u_timer (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .lnk     (lnk.tmr)
  );

  bxa_rx_matcher u_match (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .lnk     (lnk.mat)
  );

  assign lnk.rx_valid = i_rx_config_valid;
  assign lnk.rx_word  = i_rx_config_word;
  assign lnk.rx_idle  = i_rx_idle;
  // Correction count flags a cut ordered set; idle pair slips are harmless
  assign lnk.frag     = i_second_correction_seq_enable && (i_clk_cor_cnt != 3'h0);
  assign lnk.buf_err  = i_buf_status[BUF_ERR_BIT];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    restart_any = i_restart_ctl || i_negotiation_restart_input || !i_sync_ok;
    consistent  = ({lnk.match_word[15], lnk.match_word[13:0]} ==
                   {st_r.partner[15], st_r.partner[13:0]});

    if (i_adv_write) begin
      st_nxt.adv = i_adv_wdata;
    end else if (!i_mgmt_present || i_advert_config_strobe) begin
      st_nxt.adv = i_advert_config_word;
    end

    case (st_r.state)
      S_AN_ENABLE: begin
        // Standard latched here so a mid-cycle switch finishes the old one
        st_nxt.mode_sgmii = i_sgmii_mode;
        st_nxt.state      = S_AN_RESTART;
      end
      S_AN_RESTART: begin
        if (lnk.timer_done) begin
          st_nxt.state = S_ABILITY;
        end
      end
      S_ABILITY: begin
        if (lnk.ability_match && (lnk.match_word != CFG_ZERO)) begin
          st_nxt.partner = lnk.match_word;
          st_nxt.state   = S_ACK_DETECT;
        end
      end
      S_ACK_DETECT: begin
        if (lnk.ack_match && consistent) begin
          st_nxt.state = S_COMPLETE_ACK;
        end else if (lnk.ability_match && !consistent) begin
          st_nxt.state = S_AN_ENABLE;
        end
      end
      S_COMPLETE_ACK: begin
        if (lnk.ability_match && !consistent) begin
          st_nxt.state = S_AN_ENABLE;
        end else if (lnk.timer_done) begin
          st_nxt.state = S_IDLE_DETECT;
        end
      end
      S_IDLE_DETECT: begin
        if (lnk.ability_match && (lnk.match_word == CFG_ZERO)) begin
          st_nxt.state = S_AN_ENABLE;
        end else if (lnk.timer_done && lnk.idle_match) begin
          st_nxt.state = S_LINK_OK;
        end
      end
      S_LINK_OK: begin
        // Fresh config words after idles mean the partner restarted
        if (lnk.ability_match) begin
          st_nxt.state = S_AN_ENABLE;
        end
      end
      S_DISABLE: begin
        st_nxt.state = S_AN_ENABLE;
      end
      default: begin
        st_nxt.state = S_AN_ENABLE;
      end
    endcase

    // No handshake tolerates one end disabled; that mismatch is unsupported
    if (!i_an_enable) begin
      st_nxt.state = S_DISABLE;
    end else if (restart_any) begin
      st_nxt.state = S_AN_ENABLE;
    end

    // 2.5G uses the same words and timer as 1G
    if (!st_nxt.mode_sgmii) begin
      base_word = st_nxt.adv;
    end else if (i_sgmii_phy_mode) begin
      base_word = i_phy_abilities | SGMII_WORD;
    end else begin
      base_word = SGMII_WORD;
    end

    case (st_nxt.state)
      S_ABILITY: begin
        st_nxt.tx_word = base_word;
        st_nxt.tx_en   = 1'b1;
      end
      S_ACK_DETECT, S_COMPLETE_ACK: begin
        st_nxt.tx_word = base_word | ACK_MASK;
        st_nxt.tx_en   = 1'b1;
      end
      S_AN_ENABLE, S_AN_RESTART: begin
        st_nxt.tx_word = CFG_ZERO;
        st_nxt.tx_en   = 1'b1;
      end
      default: begin
        st_nxt.tx_word = CFG_ZERO;
        st_nxt.tx_en   = 1'b0;
      end
    endcase

    st_nxt.complete = (st_nxt.state == S_LINK_OK);
    st_nxt.unsup    = i_rate_2g5 && st_nxt.mode_sgmii && st_nxt.complete &&
                      (st_nxt.partner[SPEED_LO+1:SPEED_LO] != SPEED_1000);

    // Clear first so that a completion in the same cycle wins
    if (!i_irq_enable || (i_irq_status_write && !i_irq_status_wdata)) begin
      st_nxt.irq = 1'b0;
    end
    if (i_irq_enable && st_nxt.complete && !st_r.complete) begin
      st_nxt.irq = 1'b1;
    end
  end

  assign lnk.timer_start = (st_nxt.state != st_r.state) &&
                           ((st_nxt.state == S_AN_RESTART) ||
                            (st_nxt.state == S_COMPLETE_ACK) ||
                            (st_nxt.state == S_IDLE_DETECT));
  assign lnk.timer_sgmii = st_nxt.mode_sgmii;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r       <= '0;
      st_r.adv   <= ADV_RESET;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_tx_config_en         = st_r.tx_en;
  assign o_tx_config_word       = st_r.tx_word;
  assign o_advert_word          = st_r.adv;
  assign o_partner_ability      = st_r.partner;
  assign o_an_complete          = st_r.complete;
  assign o_negotiation_done_irq = st_r.irq && i_irq_enable;
  assign o_status_remote_fault  = st_r.partner[RFLT_LO+1:RFLT_LO];
  assign o_status_pause         = st_r.partner[PAUSE_LO+1:PAUSE_LO];
  assign o_status_speed         = st_r.partner[SPEED_LO+1:SPEED_LO];
  assign o_status_duplex        = st_r.partner[BIT_DUPLEX];
  assign o_status_partner_link  = st_r.partner[BIT_LINK];
  assign o_rate_unsupported     = st_r.unsup;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_ack_seen;
    i_ce && st_r.state == S_ACK_DETECT && lnk.ack_match && consistent;
  endsequence

  sequence s_idle_seen;
    i_ce && st_r.state == S_IDLE_DETECT && lnk.timer_done && lnk.idle_match;
  endsequence

  sequence s_go;
    i_ce && i_an_enable && i_sync_ok && !i_restart_ctl && !i_negotiation_restart_input;
  endsequence

  a_restart_enter: assert property (i_ce && i_an_enable &&
      (i_negotiation_restart_input || !i_sync_ok) |=> st_r.state == S_AN_ENABLE)
    else $error("restart event did not reopen negotiation");
  a_adv_sent: assert property (st_r.state == S_ABILITY && !st_r.mode_sgmii |->
      o_tx_config_en && o_tx_config_word == st_r.adv)
    else $error("advertisement not on the transmit word");
  a_vector_load: assert property (i_ce && i_mgmt_present && !i_adv_write |=>
      st_r.adv == ($past(i_advert_config_strobe) ? $past(i_advert_config_word)
                                                 : $past(st_r.adv)))
    else $error("advertisement vector strobe misused");
  a_partner_take: assert property (s_go and (st_r.state == S_ABILITY &&
      lnk.ability_match && lnk.match_word != CFG_ZERO) |=> o_partner_ability ==
      $past(lnk.match_word) && st_r.state == S_ACK_DETECT)
    else $error("partner ability not captured");
  a_done_flag: assert property (s_go and s_idle_seen |=> o_an_complete)
    else $error("completion bit not raised");
  a_ack_path: assert property (s_go and s_ack_seen |=>
      st_r.state == S_COMPLETE_ACK ##0 (o_tx_config_word[BIT_ACK] && lnk.timer_done == 1'b0))
    else $error("acknowledge did not advance the sequence");
  a_done_order: assert property ($rose(o_an_complete) |-> $past(st_r.state) ==
      S_IDLE_DETECT)
    else $error("completion reached without idle detection");
  a_phy_forward: assert property (st_r.state == S_ABILITY && st_r.mode_sgmii &&
      i_sgmii_phy_mode && $stable(i_sgmii_phy_mode) && $past(i_ce) &&
      $stable(i_phy_abilities) |-> o_tx_config_word ==
      (i_phy_abilities | SGMII_WORD))
    else $error("phy abilities not forwarded");
  a_irq_zero: assert property (!i_irq_enable |-> !o_negotiation_done_irq)
    else $error("disabled interrupt not held low");
  a_irq_rise: assert property (i_ce && i_irq_enable && st_nxt.complete &&
      !st_r.complete |=> st_r.irq [*2] or (st_r.irq ##1 $past(i_irq_status_write)))
    else $error("completion did not raise the interrupt");
  a_irq_hold: assert property (st_r.irq && i_irq_enable && !(i_ce &&
      i_irq_status_write && !i_irq_status_wdata) |=> st_r.irq)
    else $error("interrupt dropped without a clearing write");
  a_unsup_rate: assert property (o_rate_unsupported |-> st_r.mode_sgmii &&
      o_an_complete && o_status_speed != SPEED_1000)
    else $error("unsupported rate flag raised wrongly");
  a_disable_idle: assert property (i_ce && !i_an_enable |=>
      st_r.state == S_DISABLE && !o_tx_config_en && !o_an_complete)
    else $error("disabled negotiation still active");
endmodule

// >>> dv/bxa_partner.sv
// Link partner model: sends its ability word, acks once words arrive.
// Assumes the device's transmit enable and word on the core clock.
module bxa_partner (
  input  wire logic               i_clk,
  input  wire logic               i_tx_en,
  input  wire bxa_pkg::bxa_word_t i_tx_word,
  input  wire bxa_pkg::bxa_word_t i_ability,
  output logic                    o_valid = 1'b0,
  output bxa_pkg::bxa_word_t      o_word  = 16'h0000,
  output logic                    o_idle  = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  import bxa_pkg::*;
  logic      ph = 1'b0;
  bxa_word_t w;
  // Ack as soon as the device sends a non-zero word
  assign w = (i_tx_word != CFG_ZERO) ? (i_ability | ACK_MASK) : i_ability;
  always @(posedge i_clk) begin
    ph      <= ~ph;
    o_valid <= ph & i_tx_en;
    o_idle  <= ph & ~i_tx_en;
    // Word off the strobe is inverted so stale values never match
    o_word  <= (ph & i_tx_en) ? w : ~w;
  end
endmodule

// >>> dv/tb_top.sv
// Bench: drives the negotiation block against the partner model.
// Assumes short link timer counts of BX and SG cycles.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bxa_pkg::*;
  localparam int BX = 20;
  localparam int SG = 8;
  logic       clk = 0, rst_n = 0, an_en = 1, rs_ctl = 0, rs_in = 0, mgmt = 1, adv_wr = 0;
  logic       strobe = 0, sgmii = 0, phy_md = 0, r2g5 = 0, irq_en = 0, irq_wr = 0, sync = 1;
  logic       cc_en = 0, noise = 0, ce = 1;
  logic [2:0] cc_cnt = 3'h0, buf_st = 3'h0;
  bxa_word_t  adv_d = 16'h0000, cfg_w = 16'h0000, phy_ab = 16'h0000, p_ab = 16'h8000;
  bxa_word_t  lf = 16'h0011, m_adv;
  wire logic  rx_v, rx_i, tx_en, done, irq, unsup, plink, dplx;
  wire bxa_word_t rx_w, tx_w, adv_q, part;
  wire logic [1:0] rf, pz, spd;
  int         n_errors = 0, tests_run = 0, c[4];

  always #12.5 clk = ~clk;

  bxa_autoneg #(.BASEX_CYCLES(BX), .SGMII_CYCLES(SG)) dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_an_enable(an_en), .i_restart_ctl(rs_ctl),
    .i_negotiation_restart_input(rs_in), .i_mgmt_present(mgmt), .i_adv_write(adv_wr),
    .i_adv_wdata(adv_d), .i_advert_config_word(cfg_w), .i_advert_config_strobe(strobe),
    .i_sgmii_mode(sgmii), .i_sgmii_phy_mode(phy_md), .i_phy_abilities(phy_ab),
    .i_rate_2g5(r2g5), .i_irq_enable(irq_en), .i_irq_status_write(irq_wr),
    .i_irq_status_wdata(1'b0), .i_sync_ok(sync), .i_rx_config_valid(rx_v),
    .i_rx_config_word(rx_w), .i_rx_idle(rx_i), .i_second_correction_seq_enable(cc_en),
    .i_clk_cor_cnt(cc_cnt), .i_buf_status(buf_st), .o_tx_config_en(tx_en),
    .o_tx_config_word(tx_w), .o_advert_word(adv_q), .o_partner_ability(part),
    .o_an_complete(done), .o_negotiation_done_irq(irq), .o_status_remote_fault(rf),
    .o_status_pause(pz), .o_status_speed(spd), .o_status_duplex(dplx),
    .o_status_partner_link(plink), .o_rate_unsupported(unsup));

  bxa_partner peer_u (.i_clk(clk), .i_tx_en(tx_en), .i_tx_word(tx_w), .i_ability(p_ab),
    .o_valid(rx_v), .o_word(rx_w), .o_idle(rx_i));

  function automatic bxa_word_t lfsr(input bxa_word_t v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Rare fragments and buffer errors while noise is on
  always @(posedge clk) begin
    lf     <= lfsr(lf);
    cc_en  <= noise & (lf[3:0] == 4'h0);
    cc_cnt <= lf[6:4];
    buf_st <= {noise & (lf[11:8] == 4'h0), 2'h0};
  end

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Restart, then wait for completion while checking sent words
  task automatic neg(input logic sg, input logic ph, output int n);
    bxa_word_t e;
    // Caller's inputs landed at the edge before this one, so form the expectation after it
    @(posedge clk) rs_in <= 1'b1;
    e = ph ? (phy_ab | SGMII_WORD) : (sg ? SGMII_WORD : m_adv);
    @(posedge clk) rs_in <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (tx_en === 1'b1 && tx_w !== CFG_ZERO)
        chk((tx_w & ~ACK_MASK) === (e & ~ACK_MASK), "tx word");
    end while (done !== 1'b1 && n < 3000);
    if (done !== 1'b1) begin
      chk(1'b0, "no completion");
      stop_test;
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk) chk(adv_q === ADV_RESET && done === 1'b0, "reset");
    m_adv = lf;
    @(posedge clk) {adv_wr, adv_d, cfg_w} <= {1'b1, m_adv, ~m_adv};
    @(posedge clk) adv_wr <= 1'b0;
    @(negedge clk) chk(adv_q === m_adv, "adv write");
    m_adv = ~m_adv;
    @(posedge clk) strobe <= 1'b1;
    @(posedge clk) {strobe, mgmt, cfg_w} <= {2'b00, 16'h01a0};
    @(negedge clk) chk(adv_q === m_adv, "strobe load");
    m_adv = 16'h01a0;
    @(negedge clk) chk(adv_q === m_adv, "vector load");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) {irq_en, noise, r2g5, sgmii, phy_md} <= {k != 1, k > 1, k == 3, k[0], k == 3};
      p_ab <= {2'b10, lf[13:0]};
      phy_ab <= lfsr(lf);
      neg(k[0], k == 3, c[k]);
      @(negedge clk) chk((part & ~ACK_MASK) === (p_ab & ~ACK_MASK), "partner");
      chk({rf, pz} === {p_ab[13:12], p_ab[8:7]}, "fault pause");
      chk({spd, dplx, plink} === {p_ab[11:10], p_ab[12], p_ab[15]}, "speed");
      chk(unsup === (k == 3 && p_ab[11:10] != SPEED_1000), "rate");
      repeat (3) @(negedge clk);
      chk(irq === (k != 1), "irq");
      @(posedge clk) irq_wr <= 1'b1;
      @(posedge clk) {irq_wr, rs_ctl, sync} <= {1'b0, k == 0, k != 1};
      @(negedge clk) chk(irq === 1'b0, "irq clear");
      @(posedge clk) {rs_ctl, sync} <= 2'b01;
      @(negedge clk) chk(done === (k > 1), "restart");
    end
    // Frozen clock enable must hold off a restart request until it thaws
    @(posedge clk) {ce, rs_ctl} <= 2'b01;
    repeat (3) @(negedge clk);
    chk(done === 1'b1, "frozen");
    @(posedge clk) ce <= 1'b1;
    @(posedge clk) rs_ctl <= 1'b0;
    @(negedge clk) chk(done === 1'b0, "thawed");
    @(posedge clk) an_en <= 1'b0;
    repeat (2) @(negedge clk);
    chk(tx_en === 1'b0 && done === 1'b0, "disabled");
    chk(c[0] - c[1] >= 3 * (BX - SG) - 4 && c[0] - c[1] <= 3 * (BX - SG) + 4, "timer");
    stop_test;
  end
endmodule
